/* File: logic/sca_adc_ctrl.v */
`include "sca_regs.vh"
// Functional notes
// - hold edge freezes and converts both pair channels
// - done low half conversion clock at latch
// - data presented while read and select low
// - conversion 3.2 us, acquisition 0.8 us
// - full cycle is twenty conversion clocks
// - conversion clock paces the capacitor array
// - reads allowed during next conversion
// - each hold starts own pair only
// - six result registers hold until own pair's next latch
// - word is data or address, valid, sync
// - select picks direct, cycle or fifo
// - fifo order follows latch order
// - one pair may fill all six slots
// - codes 0-5 channels, 6 cycle, 7 fifo
// - latch 16.5 clocks; A, then B, C
// - latch waits for active read to end
// - repeat hold edges ignored until done
module sca_adc_ctrl (
	core_clk,
	arst_n,
	conv_clk,
	pair_a_hold_n,
	pair_b_hold_n,
	pair_c_hold_n,
	rd_n,
	cs_n,
	sel_bit_zero,
	sel_bit_one,
	sel_bit_two,
	first_input_of_pair_a,
	second_input_of_pair_a,
	first_input_of_pair_b,
	second_input_of_pair_b,
	first_input_of_pair_c,
	second_input_of_pair_c,
	add_addr,
	conv_done_n,
	first_data,
	sample_a,
	sample_b,
	sample_c,
	data_out,
	data_oe
);
	input core_clk;
	input arst_n;
	input conv_clk;
	input pair_a_hold_n;
	input pair_b_hold_n;
	input pair_c_hold_n;
	input rd_n;
	input cs_n;
	input sel_bit_zero;
	input sel_bit_one;
	input sel_bit_two;
	input [15:0] first_input_of_pair_a;
	input [15:0] second_input_of_pair_a;
	input [15:0] first_input_of_pair_b;
	input [15:0] second_input_of_pair_b;
	input [15:0] first_input_of_pair_c;
	input [15:0] second_input_of_pair_c;
	input add_addr;
	output conv_done_n;
	output first_data;
	output sample_a;
	output sample_b;
	output sample_c;
	output [15:0] data_out;
	output data_oe;
	wire core_clk;
	wire arst_n;
	wire conv_clk;
	wire pair_a_hold_n;
	wire pair_b_hold_n;
	wire pair_c_hold_n;
	wire rd_n;
	wire cs_n;
	wire sel_bit_zero;
	wire sel_bit_one;
	wire sel_bit_two;
	wire [15:0] first_input_of_pair_a;
	wire [15:0] second_input_of_pair_a;
	wire [15:0] first_input_of_pair_b;
	wire [15:0] second_input_of_pair_b;
	wire [15:0] first_input_of_pair_c;
	wire [15:0] second_input_of_pair_c;
	wire add_addr;
	reg conv_done_n;
	wire first_data;
	wire sample_a;
	wire sample_b;
	wire sample_c;
	reg [15:0] data_out;
	wire data_oe;

	// ----------------------------------------
	// conversion clock edges and read strobe
	// ----------------------------------------
	reg cclk_d_r;
	reg rd_act_d_r;
	wire clk_rise;
	wire clk_fall;
	wire rd_act;
	wire rd_end;
	wire [2:0] sel;
	assign clk_rise = conv_clk & ~cclk_d_r;
	assign clk_fall = ~conv_clk & cclk_d_r;
	assign rd_act = ~rd_n & ~cs_n;
	assign rd_end = rd_act_d_r & ~rd_act;
	assign sel = {sel_bit_two, sel_bit_one, sel_bit_zero};
	assign data_oe = rd_act;

	// ----------------------------------------
	// three pair converters
	// ----------------------------------------
	wire [2:0] busy;
	wire [2:0] req;
	wire [2:0] grant;
	wire [2:0] hold_in;
	wire latch_ok;
	assign hold_in = {pair_c_hold_n, pair_b_hold_n, pair_a_hold_n};
	// latch only outside a read, one pair per conversion clock falling edge
	assign latch_ok = ~rd_act & clk_fall;
	// A before B before C; a pair waits one clock behind the one before
	assign grant[0] = req[0] & latch_ok;
	assign grant[1] = req[1] & ~req[0] & latch_ok;
	assign grant[2] = req[2] & ~req[1] & ~req[0] & latch_ok;
	assign sample_a = busy[0];
	assign sample_b = busy[1];
	assign sample_c = busy[2];
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_pair
			// each hold reaches its own pair only
			sca_pair_conv u_pair (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.hold_n(hold_in[gi]),
				.clk_rise(clk_rise),
				.clk_fall(clk_fall),
				.latch_ok(latch_ok),
				.busy(busy[gi]),
				.latch_req(req[gi]),
				.latch_done(grant[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// result store, cycle pointer and fifo
	// ----------------------------------------
	reg [15:0] res_r [0:5];
	reg [15:0] fifo_r [0:5];
	reg [2:0] fch_r [0:5];
	reg [2:0] wp_r;
	reg [2:0] rp_r;
	reg [2:0] cnt_r;
	reg [2:0] cyc_r;
	reg addr_phase_r;
	reg [1:0] gidx;
	reg [15:0] g0;
	reg [15:0] g1;
	reg [2:0] wp1;
	reg [2:0] rp1;
	wire any_grant;
	wire fifo_pop;
	integer k;
	assign any_grant = |grant;
	assign first_data = (cnt_r != 3'd0) & (fch_r[rp_r][0] == 1'b0);
	assign fifo_pop = rd_end & (sel == `SCA_SEL_FIFO) & ~(add_addr & ~addr_phase_r);
	// pick granted pair and its two words
	always @* begin
		gidx = grant[0] ? 2'd0 : (grant[1] ? 2'd1 : 2'd2);
		g0 = grant[0] ? first_input_of_pair_a :
			(grant[1] ? first_input_of_pair_b : first_input_of_pair_c);
		g1 = grant[0] ? second_input_of_pair_a :
			(grant[1] ? second_input_of_pair_b : second_input_of_pair_c);
		wp1 = (wp_r == 3'd5) ? 3'd0 : wp_r + 3'd1;
		rp1 = (rp_r == 3'd5) ? 3'd0 : rp_r + 3'd1;
	end
	// stores, fifo queue and read pointers
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (k = 0; k < 6; k = k + 1) begin
				res_r[k] <= 16'h0000;
				fifo_r[k] <= 16'h0000;
				fch_r[k] <= 3'h0;
			end
			wp_r <= 3'd0;
			rp_r <= 3'd0;
			cnt_r <= 3'd0;
			cyc_r <= 3'd0;
			addr_phase_r <= 1'b0;
			cclk_d_r <= 1'b0;
			rd_act_d_r <= 1'b0;
			conv_done_n <= 1'b1;
		end else begin
			cclk_d_r <= conv_clk;
			rd_act_d_r <= rd_act;
			// done low from latch edge until next rise: half a clock
			if (any_grant)
				conv_done_n <= 1'b0;
			else if (clk_rise)
				conv_done_n <= 1'b1;
			if (any_grant) begin
				res_r[{gidx, 1'b0}] <= g0;
				res_r[{gidx, 1'b1}] <= g1;
			end
			// push two words per latch; full queue drops newest
			if (any_grant && (cnt_r <= 3'd4)) begin
				fifo_r[wp_r] <= g0;
				fch_r[wp_r] <= {gidx, 1'b0};
				fifo_r[wp1] <= g1;
				fch_r[wp1] <= {gidx, 1'b1};
				wp_r <= (wp1 == 3'd5) ? 3'd0 : wp1 + 3'd1;
			end
			if (fifo_pop && cnt_r != 3'd0)
				rp_r <= rp1;
			cnt_r <= cnt_r + ((any_grant && cnt_r <= 3'd4) ? 3'd2 : 3'd0)
				- ((fifo_pop && cnt_r != 3'd0) ? 3'd1 : 3'd0);
			// address word toggles with data word when appended
			if (rd_end && sel[2] && sel[1])
				addr_phase_r <= add_addr & ~addr_phase_r;
			if (rd_end && sel == `SCA_SEL_CYCLE && ~(add_addr & ~addr_phase_r))
				cyc_r <= (cyc_r == 3'd5) ? 3'd0 : cyc_r + 3'd1;
		end
	end
	// output word registered during read; old data readable mid-conversion
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out <= 16'h0000;
		end else if (rd_act) begin
			case (sel)
				`SCA_SEL_CYCLE: begin
					if (add_addr && !addr_phase_r)
						data_out <= {12'h000, 1'b1, cyc_r};
					else
						data_out <= res_r[cyc_r];
				end
				`SCA_SEL_FIFO: begin
					if (add_addr && !addr_phase_r)
						data_out <= {11'h000, first_data, cnt_r != 3'd0, fch_r[rp_r]};
					else
						data_out <= fifo_r[rp_r];
				end
				default: begin
					data_out <= res_r[sel];
				end
			endcase
		end
	end
endmodule // sca_adc_ctrl

/* File: logic/sca_pair_conv.v */
`include "sca_regs.vh"
// ----------------------------------------
// one channel pair: hold, convert, latch request
// ----------------------------------------
module sca_pair_conv (
	core_clk,
	arst_n,
	hold_n,
	clk_rise,
	clk_fall,
	latch_ok,
	busy,
	latch_req,
	latch_done
);
	input core_clk;
	input arst_n;
	input hold_n;
	input clk_rise;
	input clk_fall;
	input latch_ok;
	output busy;
	output latch_req;
	input latch_done;
	wire core_clk;
	wire arst_n;
	wire hold_n;
	wire clk_rise;
	wire clk_fall;
	wire latch_ok;
	wire latch_done;
	reg busy;
	reg latch_req;
	reg hold_d_r;
	reg armed_r;
	reg [5:0] halves_r;
	wire hold_fall;
	assign hold_fall = hold_d_r & ~hold_n;
	// hold edge freezes both channels together; later edges ignored while busy
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_d_r <= 1'b1;
			busy <= 1'b0;
			armed_r <= 1'b0;
			halves_r <= 6'd0;
			latch_req <= 1'b0;
		end else begin
			hold_d_r <= hold_n;
			if (!busy && hold_fall) begin
				busy <= 1'b1;
				armed_r <= 1'b0;
				halves_r <= 6'd0;
			end else if (busy) begin
				// start counts from next conversion clock rise
				if (!armed_r && clk_rise) begin
					armed_r <= 1'b1;
				// sixteen periods convert, latch half a period on; rest of twenty is acquisition
				end else if (armed_r && !latch_req && (clk_rise | clk_fall)) begin
					halves_r <= halves_r + 6'd1;
					// request one edge early, else the grant misses the latch fall by a period
					if (halves_r == `SCA_LATCH_HALVES - 6'd2)
						latch_req <= 1'b1;
				end
				// a grant only counts in a free latch slot
				if (latch_req && latch_done && latch_ok) begin
					latch_req <= 1'b0;
					busy <= 1'b0;
				end
			end
		end
	end
endmodule // sca_pair_conv

/* File: logic/sca_regs.vh */
`ifndef SCA_REGS_VH
`define SCA_REGS_VH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SCA_CORE_PERIOD_NS 5
`define SCA_CONV_CLK_MIN_NS 200
`define SCA_HOLD_LOW_MIN_NS 20
`define SCA_HOLD_LOW_MIN_CYC ((`SCA_HOLD_LOW_MIN_NS + `SCA_CORE_PERIOD_NS - 1) / `SCA_CORE_PERIOD_NS)
`define SCA_CONV_US_X10 32
`define SCA_ACQ_US_X10 8
// conversion clock periods
`define SCA_CYCLE_PERIODS 5'd20
`define SCA_CONV_PERIODS 5'd16
// latch at 16.5 periods: counted in half periods
`define SCA_LATCH_HALVES 6'd33
// ----------------------------------------
// select codes
// ----------------------------------------
`define SCA_SEL_CYCLE 3'h6
`define SCA_SEL_FIFO 3'h7
`define SCA_NUM_CH 6
`define SCA_FIFO_DEPTH 6
`endif

/* File: test/sca_adc_ctrl_bench.sv */
module sca_adc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic conv_clk = 1'b0;
	logic add_addr = 1'b0;
	logic [15:0] vin [6] = '{default: 16'h0000};
	logic [15:0] got;
	logic [2:0] sel;
	wire [15:0] data_out;
	wire ha_n, hb_n, hc_n, rd_n, cs_n, done_n, fd, sa, sb, sc, oe;
	int mismatches = 0;
	int comparisons = 0;
	int cdiv = 0;
	// core at 200 MHz
	always #2.5 core_clk = ~core_clk;
	// conversion clock at 5 MHz, launched on core edges like every other input
	always @(posedge core_clk) begin
		cdiv <= (cdiv == 19) ? 0 : cdiv + 1;
		if (cdiv == 19)
			conv_clk <= ~conv_clk;
	end
	sca_adc_ctrl sca_adc_ctrl_i (.core_clk(core_clk), .arst_n(arst_n), .conv_clk(conv_clk),
		.pair_a_hold_n(ha_n), .pair_b_hold_n(hb_n), .pair_c_hold_n(hc_n),
		.rd_n(rd_n), .cs_n(cs_n), .sel_bit_zero(sel[0]), .sel_bit_one(sel[1]),
		.sel_bit_two(sel[2]), .first_input_of_pair_a(vin[0]), .second_input_of_pair_a(vin[1]),
		.first_input_of_pair_b(vin[2]), .second_input_of_pair_b(vin[3]),
		.first_input_of_pair_c(vin[4]), .second_input_of_pair_c(vin[5]),
		.add_addr(add_addr), .conv_done_n(done_n), .first_data(fd), .sample_a(sa),
		.sample_b(sb), .sample_c(sc), .data_out(data_out), .data_oe(oe));
	sca_host_model sca_host_model_i (.core_clk(core_clk), .data_out(data_out),
		.pair_a_hold_n(ha_n), .pair_b_hold_n(hb_n), .pair_c_hold_n(hc_n),
		.rd_n(rd_n), .cs_n(cs_n), .sel(sel));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait for all pairs idle, then acquisition time
	task automatic wait_idle;
		int n;
		n = 0;
		while ((sa | sb | sc) !== 1'b0 && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
		check(16'(n < 2000), 16'h0001);
		repeat (170) @(posedge core_clk);
	endtask
	task automatic convert(input logic [2:0] m, input logic [15:0] base);
		@(posedge core_clk);
		for (int i = 0; i < 6; i++)
			vin[i] <= base + 16'(i);
		sca_host_model_i.hold_pulse(m);
		wait_idle();
	endtask
	task automatic rd_chk(input logic [2:0] s, input logic [15:0] exp);
		sca_host_model_i.read_word(s, 12, got);
		check(got, exp);
	endtask
	// fifo: pair order kept, six slots filled, pops to empty
	task automatic t_fifo;
		logic [15:0] exp [6] = '{16'h1002, 16'h1003, 16'h2000, 16'h2001, 16'h3000, 16'h3001};
		convert(3'h2, 16'h1000);
		convert(3'h1, 16'h2000);
		convert(3'h1, 16'h3000);
		check(16'(fd), 16'h0001);
		add_addr <= 1'b1;
		rd_chk(3'h7, 16'h001A);
		rd_chk(3'h7, exp[0]);
		add_addr <= 1'b0;
		for (int i = 1; i < 6; i++)
			rd_chk(3'h7, exp[i]);
		check(16'(fd), 16'h0000);
		$display("test fifo done");
	endtask
	// all pairs at once, then direct, cycle and address-word reads
	task automatic t_direct;
		convert(3'h7, 16'h4000);
		for (int i = 0; i < 6; i++)
			rd_chk(3'(i), 16'h4000 + 16'(i));
		for (int i = 0; i < 6; i++)
			rd_chk(3'h6, 16'h4000 + 16'(i));
		add_addr <= 1'b1;
		rd_chk(3'h6, 16'h0008);
		rd_chk(3'h6, 16'h4000);
		add_addr <= 1'b0;
		$display("test direct done");
	endtask
	// long read over the due latch; a repeat hold must not restart
	task automatic t_defer;
		convert(3'h0, 16'h5000);
		sca_host_model_i.hold_pulse(3'h1);
		repeat (300) @(posedge core_clk);
		sca_host_model_i.hold_pulse(3'h1);
		repeat (280) @(posedge core_clk);
		sca_host_model_i.read_word(3'h0, 160, got);
		check(got, 16'h4000);
		wait_idle();
		rd_chk(3'h0, 16'h5000);
		$display("test defer done");
	endtask
	// pair b converting back to back, holds twenty conversion clocks apart
	task automatic t_rate;
		int n;
		n = 0;
		convert(3'h0, 16'h6000);
		sca_host_model_i.hold_pulse(3'h2);
		while (done_n !== 1'b0 && n < 1000) begin
			@(posedge core_clk);
			n++;
		end
		check(16'(n >= 658 && n <= 697), 16'h0001);
		check(16'(sb), 16'h0000);
		for (int i = 0; i < 6; i++)
			vin[i] <= 16'h7000 + 16'(i);
		repeat (794 - n) @(posedge core_clk);
		sca_host_model_i.hold_pulse(3'h2);
		check(16'(sb), 16'h0001);
		wait_idle();
		rd_chk(3'h3, 16'h7003);
		$display("test rate done");
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		t_fifo();
		t_direct();
		t_defer();
		t_rate();
		tally_and_finish();
	end
	// watchdog well past the expected run of about 35 us
	initial begin
		#100us;
		mismatches++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule // sca_adc_ctrl_bench
bind sca_adc_ctrl sca_adc_ctrl_checker sca_adc_ctrl_checker_i (.core_clk(core_clk),
	.arst_n(arst_n), .pair_a_hold_n(pair_a_hold_n), .pair_b_hold_n(pair_b_hold_n),
	.rd_n(rd_n), .cs_n(cs_n), .conv_done_n(conv_done_n), .sample_a(sample_a),
	.sample_b(sample_b), .data_out(data_out), .data_oe(data_oe));

/* File: test/sca_adc_ctrl_checker.sv */
module sca_adc_ctrl_checker (
	input logic core_clk,
	input logic arst_n,
	input logic pair_a_hold_n,
	input logic pair_b_hold_n,
	input logic rd_n,
	input logic cs_n,
	input logic conv_done_n,
	input logic sample_a,
	input logic sample_b,
	input logic [15:0] data_out,
	input logic data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// port rules
	// ----------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic [9:0] busy_cnt_r;
	// busy span of pair a; a restarted conversion shows up as overrun
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			busy_cnt_r <= 10'h000;
		else
			busy_cnt_r <= sample_a ? busy_cnt_r + 10'h001 : 10'h000;
	end
	property p_oe_off; (rd_n || cs_n) |-> !data_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus driven outside read");
	property p_oe_on; (!rd_n && !cs_n) |-> data_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("bus idle during read");
	property p_done_pulse; $fell(conv_done_n) |-> (!conv_done_n) [*8] ##[1:30] conv_done_n;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done pulse width");
	property p_no_latch_in_read; $fell(conv_done_n) |-> !$past(data_oe); endproperty
	a_no_latch_in_read: assert property (p_no_latch_in_read) else $error("latch in read");
	property p_hold_starts; $fell(pair_a_hold_n) && !sample_a |=> sample_a; endproperty
	a_hold_starts: assert property (p_hold_starts) else $error("hold not taken");
	property p_own_pair; $fell(pair_a_hold_n) && pair_b_hold_n && !sample_b |=> !sample_b;
	endproperty
	a_own_pair: assert property (p_own_pair) else $error("wrong pair started");
	property p_latch_done; $fell(sample_a) |-> $fell(conv_done_n); endproperty
	a_latch_done: assert property (p_latch_done) else $error("latch without done");
	property p_latch_time; $fell(sample_a) |-> busy_cnt_r >= 10'd650 && busy_cnt_r <= 10'd880;
	endproperty
	a_latch_time: assert property (p_latch_time) else $error("latch time off");
	property p_read_stable; data_oe && $past(data_oe) && $past(data_oe, 2) |-> $stable(data_out);
	endproperty
	a_read_stable: assert property (p_read_stable) else $error("data moved in read");
	c_done: cover property ($fell(conv_done_n));
	c_both: cover property (sample_a && sample_b);
	c_read_busy: cover property (data_oe && sample_a);
endmodule // sca_adc_ctrl_checker

/* File: test/sca_host_model.sv */
module sca_host_model (
	input logic core_clk,
	input logic [15:0] data_out,
	output logic pair_a_hold_n,
	output logic pair_b_hold_n,
	output logic pair_c_hold_n,
	output logic rd_n,
	output logic cs_n,
	output logic [2:0] sel
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle host: holds high, no read
	initial begin
		{pair_c_hold_n, pair_b_hold_n, pair_a_hold_n} = 3'h7;
		{rd_n, cs_n} = 2'h3;
		sel = 3'h0;
	end
	// hold low 25 ns, past the minimum width
	task automatic hold_pulse(input logic [2:0] m);
		@(posedge core_clk);
		{pair_c_hold_n, pair_b_hold_n, pair_a_hold_n} <= ~m;
		repeat (5) @(posedge core_clk);
		{pair_c_hold_n, pair_b_hold_n, pair_a_hold_n} <= 3'h7;
	endtask
	// select set up first; data taken at the last edge before release
	task automatic read_word(input logic [2:0] s, input int len, output logic [15:0] d);
		@(posedge core_clk);
		sel <= s;
		repeat (2) @(posedge core_clk);
		{rd_n, cs_n} <= 2'h0;
		repeat (len) @(posedge core_clk);
		d = data_out;
		{rd_n, cs_n} <= 2'h3;
		repeat (8) @(posedge core_clk);
	endtask
endmodule // sca_host_model
